// >>> bench/ahb_cpu_model.sv
// AHB-Lite master standing in for the CPU core
`timescale 1ns/1ps
module ahb_cpu_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    initial begin
        hsel_o = 1'b1;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    // one word transfer; ok low if the slave never answers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit ok);
        int n = 0;
        haddr_o <= {24'h0, a};
        hwrite_o <= w;
        htrans_o <= 2'h2;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready_i !== 1'b1 && n < 50);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready_i !== 1'b1 && n < 50);
        q = hrdata_i;
        ok = (n < 50);
    endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the timer counter core
`timescale 1ns/1ps
module tb_top;
    import timer_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel, hwrite, hready, hresp, ovf_irq, wake, pin_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, buf3;
    logic [5:0] cap_en, cap_cfg, ch_irq;
    logic ext = 1'b0;
    logic wmode = 1'b0;
    logic smode = 1'b0;
    logic brk = 1'b0;
    logic permit = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [1:0] evs;
    int miscompares = 0;
    int num_checks = 0;
    assign evs = {wake, ovf_irq};

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    ahb_cpu_model u_ahb_cpu_model (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    timer_counter_core u_timer_counter_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hready_i(hready), .hwdata_i(hwdata), .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp),
        .external_count_clock_i(ext), .wait_mode_i(wmode), .stop_mode_i(smode), .break_i(brk),
        .break_clear_permit_i(permit), .chan_event_i(ev), .capture_enable_o(cap_en),
        .chan_capture_o(cap_cfg), .chan_buffered_o(buf3), .overflow_irq_o(ovf_irq),
        .channel_irq_o(ch_irq), .wake_o(wake), .ext_clk_pin_input_o(pin_in));

    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        bit ok;
        u_ahb_cpu_model.xfer(w, a, d, q, ok);
        if (!ok) begin
            chk("bus answer", 1, 0);
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xf(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xf(1'b0, a, 32'h0, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        rd(a, q);
        chk(what, e, q);
    endtask

    // high byte first so the low byte comes from the latch
    task automatic cnt(output logic [15:0] v);
        logic [31:0] h, l;
        rd(OFS_CNTH, h);
        rd(OFS_CNTL, l);
        v = {h[7:0], l[7:0]};
    endtask

    // bounded wait on overflow request (0) or wake (1)
    task automatic wait_hi(input int b, input string what);
        int n = 0;
        while (evs[b] !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        chk(what, 1, evs[b]);
    endtask

    task automatic pulse(input logic [5:0] v);
        ev <= v;
        @(posedge clk_i);
        ev <= 6'h00;
        @(posedge clk_i);
    endtask

    task automatic t_reset();
        rdc(OFS_CSR, 32'h20, "csr reset");
        rdc(OFS_CNTH, 32'h0, "cnth reset");
        rdc(OFS_CNTL, 32'h0, "cntl reset");
        rdc(OFS_MODH, 32'hFF, "modh reset");
        rdc(OFS_MODL, 32'hFF, "modl reset");
        rdc(8'h40, 32'h0, "unmapped");
        chk("reset outs", 32'h3F, {hresp, ovf_irq, wake, pin_in, buf3, ch_irq, cap_en});
    endtask

    task automatic t_divider();
        logic [15:0] v;
        for (int c = 0; c < 7; c++) begin
            wr(OFS_CSR, 32'h10 | 32'(c));
            repeat (128) @(posedge clk_i);
            wr(OFS_CSR, 32'h20 | 32'(c));
            cnt(v);
            chk("divided count", 1, v >= (128 >> c) && v <= (136 >> c) + 1);
        end
    endtask

    task automatic t_latch();
        logic [31:0] l1, l2;
        wr(OFS_CSR, 32'h10);
        rdc(OFS_CNTH, 32'h0, "cnth");
        repeat (6) @(posedge clk_i);
        rdc(OFS_CNTH, 32'h0, "cnth");
        wr(OFS_CSR, 32'h20);
        rd(OFS_CNTL, l1);
        rd(OFS_CNTL, l2);
        chk("latched low", 1, (l2[7:0] - l1[7:0]) >= 8);
    endtask

    task automatic t_halt_clear();
        logic [15:0] v;
        wr(OFS_CSR, 32'h00);
        repeat (10) @(posedge clk_i);
        wr(OFS_CSR, 32'h30);
        cnt(v);
        chk("halt and clear", 0, v);
        rdc(OFS_CSR, 32'h20, "clear bit");
        repeat (10) @(posedge clk_i);
        cnt(v);
        chk("halted count", 0, v);
    endtask

    task automatic t_overflow();
        logic [15:0] v;
        wr(OFS_MODL, 32'h10);
        wr(OFS_MODH, 32'h00);
        wr(OFS_CSR, 32'h50);
        repeat (60) @(posedge clk_i);
        rdc(OFS_CSR, 32'h40, "held off");
        wr(OFS_MODL, 32'h10);
        wr(OFS_CSR, 32'h50);
        wait_hi(0, "overflow");
        cnt(v);
        chk("wrapped", 1, v <= 16);
        wr(OFS_CSR, 32'h60);
        chk("lone zero write", 1, ovf_irq);
        rdc(OFS_CSR, 32'hE0, "flag");
        wr(OFS_CSR, 32'h60);
        chk("cleared", 0, ovf_irq);
        wr(OFS_CSR, 32'hE0);
        rdc(OFS_CSR, 32'h60, "one write");
        wr(OFS_CSR, 32'h40);
        wait_hi(0, "overflow");
        rdc(OFS_CSR, 32'hC0, "arm");
        repeat (20) @(posedge clk_i);
        wr(OFS_CSR, 32'h40);
        chk("voided clear", 1, ovf_irq);
        wr(OFS_CSR, 32'h20);
        chk("masked", 0, ovf_irq);
        rdc(OFS_CSR, 32'hA0, "flag");
        wr(OFS_CSR, 32'h20);
    endtask

    task automatic t_chan_break();
        logic [15:0] a, b;
        wr(OFS_MODE, 32'h0703);
        chk("modes", 9'h1C3, {buf3, cap_cfg});
        wr(OFS_CHAN, 32'h01);
        wr(OFS_CSR, 32'h00);
        pulse(6'h05);
        rdc(OFS_CHAN, 32'h0501, "events");
        chk("chan irq", 6'h01, ch_irq);
        wr(OFS_CSR, 32'h20);
        chk("capture shut", 6'h3C, cap_en);
        pulse(6'h02);
        rdc(OFS_CHAN, 32'h0501, "halted capture");
        wr(OFS_CSR, 32'h00);
        brk <= 1'b1;
        @(posedge clk_i);
        cnt(a);
        repeat (10) @(posedge clk_i);
        cnt(b);
        chk("break count", a, b);
        chk("break capture", 6'h3C, cap_en);
        wr(OFS_CHAN, 32'h01);
        rdc(OFS_CHAN, 32'h0501, "protected");
        brk <= 1'b0;
        @(posedge clk_i);
        wr(OFS_CHAN, 32'h01);
        rdc(OFS_CHAN, 32'h0001, "second step");
        pulse(6'h01);
        brk <= 1'b1;
        permit <= 1'b1;
        @(posedge clk_i);
        rdc(OFS_CHAN, 32'h0101, "flag");
        wr(OFS_CHAN, 32'h01);
        brk <= 1'b0;
        permit <= 1'b0;
        @(posedge clk_i);
        rdc(OFS_CHAN, 32'h0001, "permitted");
    endtask

    task automatic t_low_power();
        logic [15:0] a, b;
        // wide modulo so the wait-mode run cannot wrap
        wr(OFS_MODH, 32'hFF);
        wr(OFS_MODL, 32'hFF);
        cnt(a);
        wmode <= 1'b1;
        @(posedge clk_i);
        rdc(OFS_CSR, 32'h0, "wait read");
        wr(OFS_CSR, 32'h20);
        repeat (50) @(posedge clk_i);
        wmode <= 1'b0;
        @(posedge clk_i);
        cnt(b);
        chk("wait counting", 1, b - a >= 50);
        wr(OFS_MODH, 32'h00);
        wr(OFS_MODL, 32'h10);
        // drop the leftover flag so wake needs a fresh overflow
        rdc(OFS_CSR, 32'h80, "stale flag");
        wr(OFS_CSR, 32'h50);
        chk("stale cleared", 0, ovf_irq);
        wmode <= 1'b1;
        wait_hi(1, "wake");
        wmode <= 1'b0;
        wr(OFS_CSR, 32'h60);
        rdc(OFS_CSR, 32'hE0, "flag");
        wr(OFS_CSR, 32'h70);
        wr(OFS_CSR, 32'h40);
        smode <= 1'b1;
        repeat (60) @(posedge clk_i);
        chk("stop frozen", 0, ovf_irq);
        smode <= 1'b0;
        wait_hi(0, "resumed");
        wr(OFS_CSR, 32'h30);
    endtask

    task automatic t_external();
        logic [15:0] v;
        wr(OFS_CSR, 32'h37);
        chk("pin input", 1, pin_in);
        wr(OFS_CSR, 32'h07);
        // pin idles low between pulses
        repeat (5) begin
            ext <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        cnt(v);
        chk("external count", 16'h0005, v);
        wr(OFS_CSR, 32'h20);
        chk("pin freed", 0, pin_in);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_divider();
        t_latch();
        t_halt_clear();
        t_overflow();
        t_chan_break();
        t_low_power();
        t_external();
        close_out();
    end
endmodule

// >>> hdl/ahb_regport.sv
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
module ahb_regport (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic hreadyout_o,
    output logic [31:0] hrdata_o,
    output logic hresp_o,
    regbus_if.port bus
);
    import timer_pkg::*;
    bus_state_t state;
    logic write;
    logic accept;

    assign accept = hsel_i & hready_i & htrans_i[1];

    // the wait state lets read data come from a flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            write <= 1'b0;
            bus.addr <= 8'h00;
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            case (state)
                ST_ACCESS: begin
                    if (!write) begin
                        hrdata_o <= bus.rdata;
                    end
                    state <= ST_DONE;
                end
                default: begin
                    if (accept) begin
                        bus.addr <= haddr_i[7:0];
                        write <= hwrite_i;
                        state <= ST_ACCESS;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign hreadyout_o = (state != ST_ACCESS);
    assign hresp_o = 1'b0;
    assign bus.rd = ce_i & (state == ST_ACCESS) & ~write;
    assign bus.wr = ce_i & (state == ST_ACCESS) & write;
    assign bus.wdata = hwdata_i;
endmodule

// >>> hdl/count_tick.sv
// prescaler and external count clock tick source
`timescale 1ns/1ps
module count_tick (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    tick_if.gen t
);
    import timer_pkg::*;
    logic [5:0] pre;
    logic [2:0] sync;
    logic [5:0] mask;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync <= 3'h0;
        end else if (ce_i) begin
            sync <= {sync[1:0], t.ext_clk};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pre <= 6'h00;
        end else if (ce_i) begin
            if (t.clear) begin
                pre <= 6'h00;
            end else if (t.run) begin
                pre <= pre + 6'h01;
            end
        end
    end

    assign mask = 6'((7'h01 << t.sel) - 7'h01);
    // edge taken after two flops only
    assign t.tick = t.run & ~t.clear & ((t.sel == DIV_EXT) ? (sync[1] & ~sync[2]) : ((pre & mask) == mask));
endmodule

// >>> hdl/timer_counter_core.sv
// timer counter core: counter, modulo, overflow and channel flags
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module timer_counter_core (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic hreadyout_o,
    output logic [31:0] hrdata_o,
    output logic hresp_o,
    input wire logic external_count_clock_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic break_i,
    input wire logic break_clear_permit_i,
    input wire logic [timer_pkg::NCHAN-1:0] chan_event_i,
    output logic [timer_pkg::NCHAN-1:0] capture_enable_o,
    output logic [timer_pkg::NCHAN-1:0] chan_capture_o,
    output logic [2:0] chan_buffered_o,
    output logic overflow_irq_o,
    output logic [timer_pkg::NCHAN-1:0] channel_irq_o,
    output logic wake_o,
    output logic ext_clk_pin_input_o
);
    import timer_pkg::*;

    regbus_if bus ();
    tick_if tk ();

    logic overflow_flag;
    logic overflow_irq_enable;
    logic counter_halt;
    logic ovf_armed;
    logic mod_inhibit;
    logic [2:0] clock_divider_select;
    logic [15:0] count;
    logic [15:0] modulo;
    logic [7:0] low_buf;
    logic low_held;
    logic [NCHAN-1:0] channel_event_flag;
    logic [NCHAN-1:0] channel_irq_enable;
    logic [NCHAN-1:0] ch_armed;
    logic [NCHAN-1:0] ch_capt;
    logic [2:0] ch_buf;
    logic en;
    logic rd;
    logic wr;
    logic brk_lock;
    logic cnt_clear;
    logic ovf_evt;
    logic [NCHAN-1:0] ch_evt;
    logic rd_csr;
    logic wr_csr;
    logic rd_chan;
    logic wr_chan;
    logic [31:0] rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // set beats clear; clear needs a prior arming read
    function automatic logic [NCHAN-1:0] flag_upd(input logic [NCHAN-1:0] f, input logic [NCHAN-1:0] s,
                                                   input logic [NCHAN-1:0] a, input logic [NCHAN-1:0] c);
        return s | (f & ~(a & c));
    endfunction

    function automatic logic [NCHAN-1:0] arm_upd(input logic [NCHAN-1:0] f, input logic [NCHAN-1:0] s,
                                                  input logic [NCHAN-1:0] a, input logic [NCHAN-1:0] r,
                                                  input logic [NCHAN-1:0] c);
        return ~s & ((a & ~c) | (r & f));
    endfunction

    ahb_regport u_port (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hreadyout_o(hreadyout_o),
        .hrdata_o(hrdata_o),
        .hresp_o(hresp_o),
        .bus(bus.port)
    );

    count_tick u_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(en),
        .t(tk.gen)
    );

    assign en = ce_i & ~stop_mode_i;
    assign rd = bus.rd & en & ~wait_mode_i;
    assign wr = bus.wr & en & ~wait_mode_i;
    assign brk_lock = break_i & ~break_clear_permit_i;
    assign rd_csr = rd & hit(bus.addr, OFS_CSR);
    assign wr_csr = wr & hit(bus.addr, OFS_CSR);
    assign rd_chan = rd & hit(bus.addr, OFS_CHAN);
    assign wr_chan = wr & hit(bus.addr, OFS_CHAN);
    assign cnt_clear = wr_csr & bus.wdata[CSR_CLR];

    assign tk.sel = clock_divider_select;
    assign tk.clear = cnt_clear;
    assign tk.ext_clk = external_count_clock_i;
    // halt and break stop the count
    assign tk.run = ~counter_halt & ~break_i;

    // overflow event, held off mid modulo update
    assign ovf_evt = en & tk.tick & (count == modulo) & ~mod_inhibit;
    // captures blocked while halted or in break
    assign capture_enable_o = ~(ch_capt & {NCHAN{counter_halt | break_i}});
    // only permitted events set a flag
    assign ch_evt = {NCHAN{en}} & chan_event_i & capture_enable_o;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count <= 16'h0000;
        end else if (en) begin
            if (cnt_clear) begin
                count <= 16'h0000;
            end else if (tk.tick) begin
                count <= (count == modulo) ? 16'h0000 : count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            overflow_irq_enable <= 1'b0;
            counter_halt <= 1'b1;
            clock_divider_select <= DIV_RST;
        end else if (wr_csr) begin
            overflow_irq_enable <= bus.wdata[CSR_OIE];
            counter_halt <= bus.wdata[CSR_HALT];
            clock_divider_select <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            modulo <= MOD_RST;
            mod_inhibit <= 1'b0;
        end else if (wr & hit(bus.addr, OFS_MODH)) begin
            modulo[15:8] <= bus.wdata[7:0];
            mod_inhibit <= 1'b1;
        end else if (wr & hit(bus.addr, OFS_MODL)) begin
            modulo[7:0] <= bus.wdata[7:0];
            mod_inhibit <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            overflow_flag <= 1'b0;
            ovf_armed <= 1'b0;
        end else if (en) begin
            overflow_flag <= flag_upd(6'(overflow_flag), 6'(ovf_evt), 6'(ovf_armed),
                                      6'(wr_csr & ~bus.wdata[CSR_OVF] & ~brk_lock))
                             != 6'h00;
            ovf_armed <= arm_upd(6'(overflow_flag), 6'(ovf_evt), 6'(ovf_armed),
                                 6'(rd_csr & ~brk_lock), 6'(wr_csr & ~bus.wdata[CSR_OVF] & ~brk_lock))
                         != 6'h00;
        end
    end

    // channel flags use the same two-step clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_event_flag <= '0;
            ch_armed <= '0;
        end else if (en) begin
            channel_event_flag <= flag_upd(channel_event_flag, ch_evt, ch_armed,
                                           {NCHAN{wr_chan & ~brk_lock}}
                                           & ~bus.wdata[CHAN_FLAG_LSB +: NCHAN]);
            ch_armed <= arm_upd(channel_event_flag, ch_evt, ch_armed, {NCHAN{rd_chan & ~brk_lock}},
                                {NCHAN{wr_chan & ~brk_lock}} & ~bus.wdata[CHAN_FLAG_LSB +: NCHAN]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_irq_enable <= '0;
            ch_capt <= '0;
            ch_buf <= 3'h0;
        end else if (wr_chan) begin
            channel_irq_enable <= bus.wdata[NCHAN-1:0];
        end else if (wr & hit(bus.addr, OFS_MODE)) begin
            ch_capt <= bus.wdata[NCHAN-1:0];
            ch_buf <= bus.wdata[MODE_BUF_LSB +: 3];
        end
    end

    // low byte latch, kept across break
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            low_buf <= 8'h00;
            low_held <= 1'b0;
        end else if (cnt_clear) begin
            low_buf <= 8'h00;
            low_held <= 1'b0;
        end else if (rd & hit(bus.addr, OFS_CNTL)) begin
            low_held <= 1'b0;
        end else if (rd & hit(bus.addr, OFS_CNTH) & ~low_held) begin
            low_buf <= count[7:0];
            low_held <= 1'b1;
        end
    end

    // unmapped and wait-mode reads return zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (wait_mode_i) begin
            rdata = 32'h0000_0000;
        end else if (hit(bus.addr, OFS_CSR)) begin
            rdata[7:0] = {overflow_flag, overflow_irq_enable, counter_halt, 2'h0, clock_divider_select};
        end else if (hit(bus.addr, OFS_CNTH)) begin
            rdata[7:0] = count[15:8];
        end else if (hit(bus.addr, OFS_CNTL)) begin
            rdata[7:0] = low_held ? low_buf : count[7:0];
        end else if (hit(bus.addr, OFS_MODH)) begin
            rdata[7:0] = modulo[15:8];
        end else if (hit(bus.addr, OFS_MODL)) begin
            rdata[7:0] = modulo[7:0];
        end else if (hit(bus.addr, OFS_CHAN)) begin
            rdata[CHAN_FLAG_LSB +: NCHAN] = channel_event_flag;
            rdata[NCHAN-1:0] = channel_irq_enable;
        end else if (hit(bus.addr, OFS_MODE)) begin
            rdata[MODE_BUF_LSB +: 3] = ch_buf;
            rdata[NCHAN-1:0] = ch_capt;
        end
    end
    assign bus.rdata = rdata;

    assign overflow_irq_o = overflow_flag & overflow_irq_enable & ~mod_inhibit;
    assign channel_irq_o = channel_event_flag & channel_irq_enable;
    assign wake_o = wait_mode_i & (overflow_irq_o | (|channel_irq_o));
    assign ext_clk_pin_input_o = (clock_divider_select == DIV_EXT);
    assign chan_capture_o = ch_capt;
    assign chan_buffered_o = ch_buf;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_arm;
        en && rd_csr && overflow_flag && !brk_lock && !ovf_evt;
    endsequence
    sequence s_zero_write;
        en && wr_csr && !bus.wdata[CSR_OVF] && !brk_lock && !ovf_evt;
    endsequence
    sequence s_high_read;
        en && rd && hit(bus.addr, OFS_CNTH) && !low_held && !cnt_clear;
    endsequence
    sequence s_low_read;
        en && rd && hit(bus.addr, OFS_CNTL) && !cnt_clear;
    endsequence
    sequence s_chan_zero;
        en && wr_chan && !brk_lock && ch_evt == '0;
    endsequence

    a_ovf_set: assert property (ovf_evt |=> overflow_flag)
        else $error("overflow event did not set flag");
    a_ovf_request: assert property ($rose(overflow_flag) && overflow_irq_enable && !mod_inhibit
                                    |-> overflow_irq_o)
        else $error("overflow request missing");
    a_chan_request: assert property (|(ch_evt & channel_irq_enable) |=> |channel_irq_o)
        else $error("channel request missing");
    a_wait_block: assert property (wait_mode_i && bus.wr |=> $stable(modulo))
        else $error("register written in wait mode");
    a_stop_freeze: assert property (stop_mode_i |=> $stable(count) && $stable(overflow_flag))
        else $error("state changed in stop mode");
    a_break_hold: assert property (break_i && !cnt_clear |=> $stable(count))
        else $error("counter moved during break");
    a_break_protect: assert property (brk_lock && overflow_flag |=> overflow_flag)
        else $error("flag cleared while protected");
    a_arm_step: assert property (s_arm |=> ovf_armed)
        else $error("status read did not arm the clear");
    a_clear_seq: assert property (ovf_armed ##0 s_zero_write |=> !overflow_flag)
        else $error("two-step clear failed");
    a_no_lone_clear: assert property (overflow_flag && !ovf_armed |=> overflow_flag)
        else $error("flag cleared without arming");
    a_halt_clear: assert property (en && cnt_clear && bus.wdata[CSR_HALT] |=> (count == 16'h0000) [*2])
        else $error("counter not held at zero");
    a_wrap_zero: assert property (en && tk.tick && !cnt_clear && count == modulo |=> count == 16'h0000)
        else $error("counter did not wrap");
    a_mod_guard: assert property (mod_inhibit |-> !overflow_irq_o ##1 !$rose(overflow_flag))
        else $error("overflow during modulo update");
    a_low_latch: assert property (low_held && !rd && !cnt_clear |=> $stable(low_buf))
        else $error("latched low byte changed");

    a_one_write: assert property (en && wr_csr && bus.wdata[CSR_OVF] && !overflow_flag && !ovf_evt
                                  |=> !overflow_flag)
        else $error("writing one set the overflow flag");
    a_clear_zero: assert property (en && cnt_clear |=> count == 16'h0000)
        else $error("clear bit did not zero the counter");
    a_halt_freeze: assert property (counter_halt && !cnt_clear |=> $stable(count))
        else $error("counter moved while halted");
    a_div_tick: assert property (tk.run && !tk.clear && clock_divider_select == DIV_RST |-> tk.tick)
        else $error("undivided clock missed a tick");
    a_wait_count: assert property (wait_mode_i && en && tk.tick && !cnt_clear && count != modulo
                                   |=> count == $past(count) + 16'h0001)
        else $error("counter stalled in wait mode");
    a_stop_regs: assert property (stop_mode_i |=> $stable(modulo) && $stable(counter_halt) && $stable(low_buf))
        else $error("register changed in stop mode");
    a_chan_set: assert property (|ch_evt |=> (channel_event_flag & $past(ch_evt)) == $past(ch_evt))
        else $error("channel event did not set its flag");
    a_chan_protect: assert property (brk_lock |=>
                                     (channel_event_flag & $past(channel_event_flag)) == $past(channel_event_flag))
        else $error("channel flag cleared while protected");
    a_chan_clear: assert property (s_chan_zero |=>
                                   (channel_event_flag & $past(ch_armed & ~bus.wdata[CHAN_FLAG_LSB +: NCHAN])) == '0)
        else $error("armed channel flag not cleared");
    a_mod_release: assert property (en && wr && hit(bus.addr, OFS_MODL) |=> !mod_inhibit)
        else $error("modulo low write left overflow held off");
    a_latch_take: assert property (s_high_read |=> low_held && low_buf == $past(count[7:0]))
        else $error("high byte read did not latch low byte");
    a_latch_free: assert property (s_low_read |=> !low_held)
        else $error("low byte read did not release latch");
    a_break_latch: assert property (break_i && low_held && !cnt_clear && !(rd && hit(bus.addr, OFS_CNTL))
                                    |=> low_held)
        else $error("latch released during break");
endmodule

// >>> pkg/timer_ifs.sv
// register strobe bundle and counter tick bundle
`timescale 1ns/1ps
interface regbus_if;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport port (output rd, output wr, output addr, output wdata, input rdata);
    modport regs (input rd, input wr, input addr, input wdata, output rdata);
endinterface

interface tick_if;
    logic [2:0] sel;
    logic clear;
    logic run;
    logic ext_clk;
    logic tick;
    modport ctl (output sel, output clear, output run, output ext_clk, input tick);
    modport gen (input sel, input clear, input run, input ext_clk, output tick);
endinterface

// >>> pkg/timer_pkg.sv
// constants and types shared by the timer counter core
package timer_pkg;
    localparam int NCHAN = 6;
    localparam logic [7:0] OFS_CSR = 8'h00;
    localparam logic [7:0] OFS_CNTH = 8'h04;
    localparam logic [7:0] OFS_CNTL = 8'h08;
    localparam logic [7:0] OFS_MODH = 8'h0C;
    localparam logic [7:0] OFS_MODL = 8'h10;
    localparam logic [7:0] OFS_CHAN = 8'h14;
    localparam logic [7:0] OFS_MODE = 8'h18;
    localparam int CSR_OVF = 7;
    localparam int CSR_OIE = 6;
    localparam int CSR_HALT = 5;
    localparam int CSR_CLR = 4;
    localparam int CHAN_FLAG_LSB = 8;
    localparam int MODE_BUF_LSB = 8;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_EXT = 3'h7;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    typedef enum {ST_IDLE, ST_ACCESS, ST_DONE} bus_state_t;
endpackage
